/* logic/sbp_ctl.sv */
// Controller end: AHB-Lite register slave that issues paced commands on the link.
`include "sbp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sbp_ctl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Link to the device
   sbp_link_if.ctl link
);
   import sbp_pkg::*;

   // ==========================================================================
   // Bus phase and registers
   logic ph_v;
   logic ph_w;
   logic [7:0] ph_a;
   sbp_ctl_state_t state;
   sbp_cmd_t q_op;
   logic [1:0] q_ba;
   logic q_a10;
   logic [9:0] q_addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rvld;
   logic [2:0] c_bl;
   logic [1:0] c_cl;
   logic c_wbm;
   logic [1:0] mcnt;
   logic [4:0] rd_busy;
   logic [3:0] wr_left;
   logic [4:0] ag [0:3];
   logic [4:0] pg [0:3];
   logic [3:0] ag_z;
   logic [3:0] pg_z;

   wire logic busy = (state != SBP_CS_IDLE);
   wire logic cmd_wr = ph_v && ph_w && (ph_a == `SBP_REG_CMD);
   wire logic bus_done = ph_v && o_hreadyout;
   wire logic is_wr = (q_op == SBP_CMD_WRITE);
   wire logic all_bank = ((q_op == SBP_CMD_PRE) && q_a10) || (q_op == SBP_CMD_MRS);
   // act, read and write wait the bank's guard; precharge also waits recovery
   wire logic ok_one = ag_z[q_ba] && ((q_op != SBP_CMD_PRE) || pg_z[q_ba]);
   wire logic ok = all_bank ? ((&ag_z) && (&pg_z)) : ok_one;
   // a write that follows read data masks the bus first
   wire logic need_mask = is_wr && (rd_busy != 5'h00);
   wire logic issue = ((state == SBP_CS_WAIT) && ok && !need_mask) || ((state == SBP_CS_MASK) && (mcnt == 2'h1));
   wire logic mask_go = (state == SBP_CS_WAIT) && ok && need_mask;
   // a read ends the running write data at once
   wire logic rd_issue = issue && (q_op == SBP_CMD_READ);
   wire logic [4:0] clen = (is_wr && c_wbm) ? 5'h01 : (5'h01 << c_bl[1:0]);
   // auto precharge guard counted as the latest legal explicit precharge
   wire logic [4:0] ap_guard = clen + 5'(`SBP_ROW_ACTIVE_TIME_CYC) + 5'(`SBP_TRP_CYC) + (is_wr ? 5'(`SBP_TWR_CYC) : 5'h00);

   assign o_hreadyout = !(cmd_wr && busy);
   assign o_hresp = 1'b0;
   assign o_hrdata = (ph_a == `SBP_REG_STATUS) ? {30'h0, rvld, busy} :
                     (ph_a == `SBP_REG_RDATA) ? {16'h0000, rdata} :
                     (ph_a == `SBP_REG_WDATA) ? {16'h0000, wdata} : 32'h0;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ph_v <= 1'b0;
         ph_w <= 1'b0;
         ph_a <= 8'h00;
      end else if (i_hready) begin
         ph_v <= i_hsel && i_htrans[1];
         ph_w <= i_hwrite;
         ph_a <= i_haddr[7:0];
      end
   end

   // ==========================================================================
   // Command sequencer
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= SBP_CS_IDLE;
         q_op <= SBP_CMD_NOP;
         q_ba <= 2'h0;
         q_a10 <= 1'b0;
         q_addr <= 10'h000;
         mcnt <= 2'h0;
      end else begin
         unique case (state)
            SBP_CS_IDLE: begin
               if (bus_done && cmd_wr) begin
                  q_op <= sbp_cmd_t'(i_hwdata[`SBP_CW_OP]);
                  q_ba <= i_hwdata[`SBP_CW_BA];
                  q_a10 <= i_hwdata[`SBP_CW_A10];
                  q_addr <= i_hwdata[`SBP_CW_ADDR];
                  state <= SBP_CS_WAIT;
               end
            end
            SBP_CS_WAIT: begin
               if (issue) begin
                  state <= SBP_CS_IDLE;
               end else if (ok && need_mask) begin
                  state <= SBP_CS_MASK;
                  mcnt <= `SBP_MASK_CYC;
               end
            end
            SBP_CS_MASK: begin
               mcnt <= mcnt - 2'h1;
               if (issue) begin
                  state <= SBP_CS_IDLE;
               end
            end
            default: begin
               state <= SBP_CS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Link drive, data and mode snoop
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         link.cmd <= SBP_CMD_NOP;
         link.ba <= 2'h0;
         link.a10 <= 1'b0;
         link.addr <= 10'h000;
         link.dqm <= 1'b0;
         link.dq_ctl <= 16'h0000;
         link.dq_ctl_oe <= 1'b0;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         rvld <= 1'b0;
         c_bl <= 3'h0;
         c_cl <= `SBP_CL_RST;
         c_wbm <= 1'b0;
         rd_busy <= 5'h00;
         wr_left <= 4'h0;
      end else begin
         link.cmd <= issue ? q_op : SBP_CMD_NOP;
         link.ba <= q_ba;
         link.a10 <= q_a10;
         link.addr <= q_addr;
         // the mask stands for the two cycles before the write
         link.dqm <= ((state == SBP_CS_MASK) && !issue) || mask_go;
         link.dq_ctl <= wdata;
         link.dq_ctl_oe <= (issue && is_wr) || ((wr_left > 4'h1) && !rd_issue);
         if (issue && is_wr) begin
            wr_left <= clen[3:0];
         end else if (rd_issue) begin
            wr_left <= 4'h0;
         end else if (wr_left != 4'h0) begin
            wr_left <= wr_left - 4'h1;
         end
         if (rd_issue) begin
            rd_busy <= clen + 5'(c_cl);
         end else if (rd_busy != 5'h00) begin
            rd_busy <= rd_busy - 5'h01;
         end
         if (issue && (q_op == SBP_CMD_MRS)) begin
            c_bl <= q_addr[`SBP_MODE_BL];
            c_cl <= q_addr[`SBP_MODE_CL];
            c_wbm <= q_addr[`SBP_MODE_WBM];
         end
         if (bus_done && ph_w && (ph_a == `SBP_REG_WDATA)) begin
            wdata <= i_hwdata[15:0];
         end
         if (link.dq_dev_oe) begin
            rdata <= link.dq_dev;
         end
         // A new word wins over a read of the data register in the same cycle.
         rvld <= link.dq_dev_oe || (rvld && !(bus_done && !ph_w && (ph_a == `SBP_REG_RDATA)));
      end
   end

   // ==========================================================================
   // Per-bank guards
   genvar gi;
   for (gi = 0; gi < 4; gi = gi + 1) begin : g_guard
      wire logic hit = issue && (all_bank || (q_ba == 2'(gi)));
      assign ag_z[gi] = (ag[gi] == 5'h00);
      assign pg_z[gi] = (pg[gi] == 5'h00);
      always_ff @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            ag[gi] <= 5'h00;
            pg[gi] <= 5'h00;
         end else begin
            if (hit && (q_op == SBP_CMD_PRE)) begin
               ag[gi] <= 5'(`SBP_TRP_CYC);
            end else if (hit && (q_op != SBP_CMD_ACT) && (q_op != SBP_CMD_MRS) && q_a10) begin
               ag[gi] <= ap_guard;
            end else if (!ag_z[gi]) begin
               ag[gi] <= ag[gi] - 5'h01;
            end
            // recovery after the last write data before a precharge
            if (hit && is_wr) begin
               pg[gi] <= clen - 5'h01 + 5'(`SBP_TWR_CYC);
            end else if (!pg_z[gi]) begin
               pg[gi] <= pg[gi] - 5'h01;
            end
         end
      end
   end
endmodule // sbp_ctl
`default_nettype wire

/* logic/sbp_defines.svh */
// Constants of the SDRAM bank precharge block: timing, mode fields, register map.
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH
// ==========================================================================
// Clock and timing
`define SBP_CLK_NS 40
`define SBP_TRP_NS 18
`define SBP_TWR_NS 15
`define SBP_ROW_ACTIVE_TIME_NS 42
// Least times round up to whole clock cycles.
`define SBP_TRP_CYC (((`SBP_TRP_NS) + (`SBP_CLK_NS) - 1) / (`SBP_CLK_NS))
`define SBP_TWR_CYC (((`SBP_TWR_NS) + (`SBP_CLK_NS) - 1) / (`SBP_CLK_NS))
`define SBP_ROW_ACTIVE_TIME_CYC (((`SBP_ROW_ACTIVE_TIME_NS) + (`SBP_CLK_NS) - 1) / (`SBP_CLK_NS))
// ==========================================================================
// Mode word fields carried on the address lines
`define SBP_MODE_BL 2:0
`define SBP_MODE_CL 5:4
`define SBP_MODE_WBM 9
`define SBP_BL_CONT 3'h7
`define SBP_COL 3:0
`define SBP_MASK_CYC 2'h2
`define SBP_CL_RST 2'h2
// ==========================================================================
// Controller register map and command word fields
`define SBP_REG_CMD 8'h00
`define SBP_REG_WDATA 8'h04
`define SBP_REG_STATUS 8'h08
`define SBP_REG_RDATA 8'h0c
`define SBP_CW_OP 2:0
`define SBP_CW_BA 5:4
`define SBP_CW_A10 6
`define SBP_CW_ADDR 25:16
`endif

/* logic/sbp_pkg.sv */
// Types shared by both ends of the SDRAM bank precharge link.
package sbp_pkg;
   typedef enum logic [2:0] {
      SBP_CMD_NOP = 3'h0,
      SBP_CMD_ACT = 3'h1,
      SBP_CMD_READ = 3'h2,
      SBP_CMD_WRITE = 3'h3,
      SBP_CMD_PRE = 3'h4,
      SBP_CMD_MRS = 3'h5
   } sbp_cmd_t;
   typedef enum logic [2:0] {
      SBP_BANK_IDLE = 3'h1,
      SBP_BANK_ACTIVE = 3'h2,
      SBP_BANK_PRECH = 3'h4
   } sbp_bank_t;
   typedef enum logic [2:0] {
      SBP_CS_IDLE = 3'h1,
      SBP_CS_WAIT = 3'h2,
      SBP_CS_MASK = 3'h4
   } sbp_ctl_state_t;
endpackage

/* logic/sbp_link_if.sv */
// Command, address, mask and data link between controller and memory device.
`timescale 1ns/100ps
`default_nettype none
interface sbp_link_if;
   import sbp_pkg::*;
   sbp_cmd_t cmd;
   logic [1:0] ba;
   logic a10;
   logic [9:0] addr;
   logic dqm;
   logic [15:0] dq_ctl;
   logic dq_ctl_oe;
   logic [15:0] dq_dev;
   logic dq_dev_oe;
   modport dev(input cmd, ba, a10, addr, dqm, dq_ctl, dq_ctl_oe, output dq_dev, dq_dev_oe);
   modport ctl(output cmd, ba, a10, addr, dqm, dq_ctl, dq_ctl_oe, input dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

/* logic/sbp_device.sv */
// Memory device end: per-bank precharge, auto precharge and burst tracking.
`include "sbp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sbp_device (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Link to the controller
   sbp_link_if.dev link,
   // Bank status
   output logic [3:0] o_bank_idle
);
   import sbp_pkg::*;

   // ==========================================================================
   // Mode and burst state
   logic [2:0] bl_code;
   logic [1:0] cl;
   logic wbm;
   logic b_act;
   logic b_wr;
   logic [1:0] b_bank;
   logic [3:0] b_col;
   logic [3:0] b_left;
   logic b_cont;
   logic b_ap;
   logic [2:0] rp_v;
   logic [1:0] dm_q;
   logic [15:0] rp_d [0:2];
   logic [15:0] mem [0:63];
   sbp_bank_t bstate [0:3];
   logic [3:0] ptimer [0:3];
   logic [3:0] ras_cnt [0:3];
   logic pend [0:3];
   logic [3:0] pwait [0:3];

   // ==========================================================================
   // Command decode
   wire logic is_rd = (link.cmd == SBP_CMD_READ);
   wire logic is_wr = (link.cmd == SBP_CMD_WRITE);
   wire logic is_pre = (link.cmd == SBP_CMD_PRE);
   wire logic is_act = (link.cmd == SBP_CMD_ACT);
   wire logic is_mrs = (link.cmd == SBP_CMD_MRS);
   wire logic acc_ok = (is_rd | is_wr) && (bstate[link.ba] == SBP_BANK_ACTIVE);
   wire logic cont = (bl_code == `SBP_BL_CONT);
   // single write beat when wbm is set; reads and other writes use burst length
   wire logic [3:0] new_len = (is_wr && wbm) ? 4'h1 : (4'h1 << bl_code[1:0]);
   // continuous bursts drop the request; continuous wins; per command
   wire logic new_ap = link.a10 && !cont;

   // ==========================================================================
   // Current beat: a new access takes the beat from a running burst
   wire logic beat_v = acc_ok | b_act;
   wire logic beat_wr = acc_ok ? is_wr : b_wr;
   wire logic [1:0] beat_bank = acc_ok ? link.ba : b_bank;
   wire logic [3:0] beat_col = acc_ok ? link.addr[`SBP_COL] : b_col;
   wire logic [3:0] left_after = acc_ok ? (new_len - 4'h1) : (b_left - 4'h1);
   wire logic cur_cont = acc_ok ? cont : b_cont;
   wire logic cur_ap = acc_ok ? new_ap : b_ap;
   wire logic end_now = beat_v && !cur_cont && (left_after == 4'h0);
   // another bank's access interrupts an auto-precharge burst
   wire logic intr = acc_ok && b_act && b_ap && (link.ba != b_bank);
   wire logic trunc = is_pre && (link.a10 || (link.ba == b_bank));
   wire logic [15:0] rd_word = mem[{beat_bank, beat_col}];
   wire logic [1:0] rsel = (cl == 2'h0) ? 2'h0 : (cl - 2'h1);

   assign link.dq_dev = rp_d[rsel];
   // mask lags two clocks, so the bus is free for the write
   assign link.dq_dev_oe = rp_v[rsel] && !dm_q[1];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bl_code <= 3'h0;
         cl <= `SBP_CL_RST;
         wbm <= 1'b0;
      end else if (is_mrs) begin
         bl_code <= link.addr[`SBP_MODE_BL];
         cl <= link.addr[`SBP_MODE_CL];
         wbm <= link.addr[`SBP_MODE_WBM];
      end
   end

   // ==========================================================================
   // Burst tracker
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         b_act <= 1'b0;
         b_wr <= 1'b0;
         b_bank <= 2'h0;
         b_col <= 4'h0;
         b_left <= 4'h0;
         b_cont <= 1'b0;
         b_ap <= 1'b0;
      end else if (acc_ok) begin
         b_act <= !end_now;
         b_wr <= is_wr;
         b_bank <= link.ba;
         b_col <= beat_col + 4'h1;
         b_left <= left_after;
         b_cont <= cont;
         b_ap <= new_ap;
      end else if (b_act) begin
         b_act <= !end_now && !trunc;
         b_col <= beat_col + 4'h1;
         b_left <= left_after;
      end
   end

   // Array writes carry no reset; contents are undefined until written.
   always_ff @(posedge i_clk) begin
      if (beat_v && beat_wr && !link.dqm) begin
         mem[{beat_bank, beat_col}] <= link.dq_ctl;
      end
   end

   // ==========================================================================
   // Read latency pipeline
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rp_v <= 3'h0;
         dm_q <= 2'h0;
         rp_d[0] <= 16'h0000;
         rp_d[1] <= 16'h0000;
         rp_d[2] <= 16'h0000;
      end else begin
         // a write turns the bus round, pending read words are dropped
         rp_v <= (is_wr && acc_ok) ? 3'h0 : {rp_v[1:0], beat_v && !beat_wr};
         rp_d[0] <= rd_word;
         rp_d[1] <= rp_d[0];
         rp_d[2] <= rp_d[1];
         dm_q <= {dm_q[0], link.dqm};
      end
   end

   // ==========================================================================
   // Per-bank state
   genvar gi;
   for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      wire logic act_hit = is_act && (link.ba == 2'(gi)) && (bstate[gi] == SBP_BANK_IDLE);
      // one selected bank; all banks, select bits ignored
      wire logic pre_hit = is_pre && (link.a10 || (link.ba == 2'(gi)));
      wire logic int_hit = intr && (b_bank == 2'(gi));
      // completion of a burst that asked for precharge
      wire logic end_hit = end_now && cur_ap && (beat_bank == 2'(gi));
      wire logic set_wr = int_hit ? b_wr : beat_wr;
      wire logic ras_ok = (ras_cnt[gi] >= 4'(`SBP_ROW_ACTIVE_TIME_CYC));
      assign o_bank_idle[gi] = (bstate[gi] == SBP_BANK_IDLE);
      // bank state, pending flag and timers
      always_ff @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            bstate[gi] <= SBP_BANK_IDLE;
            ptimer[gi] <= 4'h0;
            ras_cnt[gi] <= 4'h0;
            pend[gi] <= 1'b0;
            pwait[gi] <= 4'h0;
         end else begin
            unique case (bstate[gi])
               SBP_BANK_IDLE: begin
                  if (act_hit) begin
                     bstate[gi] <= SBP_BANK_ACTIVE;
                     ras_cnt[gi] <= 4'h0;
                  end
               end
               SBP_BANK_ACTIVE: begin
                  if (!ras_ok) begin
                     ras_cnt[gi] <= ras_cnt[gi] + 4'h1;
                  end
                  if (pre_hit) begin
                     bstate[gi] <= SBP_BANK_PRECH;
                     ptimer[gi] <= 4'(`SBP_TRP_CYC);
                     pend[gi] <= 1'b0;
                  end else if (int_hit || end_hit) begin
                     pend[gi] <= 1'b1;
                     // write recovery when the interrupted burst was a write; same for an ending write
                     pwait[gi] <= set_wr ? 4'(`SBP_TWR_CYC) : 4'h0;
                  end else if (pend[gi]) begin
                     if (pwait[gi] != 4'h0) begin
                        pwait[gi] <= pwait[gi] - 4'h1;
                     // hold the internal precharge for row active time
                     end else if (ras_ok) begin
                        bstate[gi] <= SBP_BANK_PRECH;
                        ptimer[gi] <= 4'(`SBP_TRP_CYC);
                        pend[gi] <= 1'b0;
                     end
                  end
               end
               SBP_BANK_PRECH: begin
                  // idle once the row precharge time has run
                  if (ptimer[gi] <= 4'h1) begin
                     bstate[gi] <= SBP_BANK_IDLE;
                  end
                  ptimer[gi] <= (ptimer[gi] == 4'h0) ? 4'h0 : (ptimer[gi] - 4'h1);
               end
               default: begin
                  bstate[gi] <= SBP_BANK_IDLE;
               end
            endcase
         end
      end
   end
endmodule // sbp_device
`default_nettype wire

/* bench/sbp_checker.sv */
// Concurrent checks on the link between the controller and the memory device.
`timescale 1ns/100ps
`default_nettype none
module sbp_checker (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Link and bank status
   input wire sbp_pkg::sbp_cmd_t cmd,
   input wire logic [1:0] ba,
   input wire logic a10,
   input wire logic [9:0] addr,
   input wire logic dqm,
   input wire logic dq_ctl_oe,
   input wire logic dq_dev_oe,
   input wire logic [3:0] o_bank_idle
);
   import sbp_pkg::*;
   logic [2:0] bl_q;
   logic [1:0] cl_q;
   logic [1:0] cba;
   logic [1:0] apb;
   wire logic is_acc = (cmd == SBP_CMD_READ) || (cmd == SBP_CMD_WRITE);
   // ======================================================================
   // Mode word and banks seen on the link
   // The auto precharge bank is kept apart, since the interrupting access moves cba.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bl_q <= 3'h0;
         cl_q <= 2'h2;
         cba <= 2'h0;
         apb <= 2'h0;
      end else if (cmd != SBP_CMD_NOP) begin
         cba <= ba;
         if (is_acc && a10) begin
            apb <= ba;
         end
         if (cmd == SBP_CMD_MRS) begin
            bl_q <= addr[2:0];
            cl_q <= addr[5:4];
         end
      end
   end
   // ======================================================================
   // Assertions
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   AST_PRE_ONE: assert property (cmd == SBP_CMD_PRE && !a10 |=> ##[0:2] o_bank_idle[cba])
      else $error("Single precharge left its bank open.");
   AST_PRE_ALL: assert property (cmd == SBP_CMD_PRE && a10 |=> ##[0:2] o_bank_idle == 4'hf)
      else $error("Precharge of all banks left a bank open.");
   AST_PRE_WAIT: assert property (cmd == SBP_CMD_PRE && !a10 && !o_bank_idle[ba] |=> !o_bank_idle[cba])
      else $error("Bank idle before the precharge time.");
   AST_ACC_ACTIVE: assert property (is_acc |-> !o_bank_idle[ba])
      else $error("Access issued to an idle bank.");
   AST_ACT_IDLE: assert property (cmd == SBP_CMD_ACT |-> o_bank_idle[ba])
      else $error("Activate issued before the bank was idle.");
   AST_RD_LAT: assert property (cmd == SBP_CMD_READ && !o_bank_idle[ba] && cl_q == 2'h2 |-> ##2 dq_dev_oe)
      else $error("Read word missing at the read latency.");
   AST_AP_DONE: assert property (is_acc && a10 && bl_q != 3'h7 && !o_bank_idle[ba] |=> ##[0:14] o_bank_idle[apb])
      else $error("Auto precharge did not close the bank.");
   AST_RAS_LOCK: assert property (cmd == SBP_CMD_ACT && o_bank_idle[ba] |=> !o_bank_idle[cba] [*2])
      else $error("Bank closed before the row active time.");
   AST_AP_ONCE: assert property (cmd == SBP_CMD_READ && !a10 && !o_bank_idle[ba] |=> !o_bank_idle[cba] [*4])
      else $error("Bank closed after a read without auto precharge.");
   AST_CONT_OPEN: assert property (is_acc && a10 && bl_q == 3'h7 |=> !o_bank_idle[cba] [*8])
      else $error("Continuous burst was auto precharged.");
   AST_DQM_LEAD: assert property ($rose(dqm) |-> dqm [*2] ##[0:1] cmd == SBP_CMD_WRITE)
      else $error("Mask lead before a write is not two cycles.");
   AST_WR_PRE: assert property (cmd == SBP_CMD_WRITE |=> cmd != SBP_CMD_PRE)
      else $error("Precharge issued inside the write recovery time.");
   AST_NO_CONTEND: assert property (!(dq_ctl_oe && dq_dev_oe))
      else $error("Controller and device drove the data bus together.");
endmodule // sbp_checker
`default_nettype wire

/* bench/tb_sdram_bank_precharge_control.sv */
// Self-checking bench: AHB-Lite orders drive the controller, which drives the device.
`timescale 1ns/100ps
`default_nettype none
module tb_sdram_bank_precharge_control;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   wire logic hready;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [3:0] bank_idle;
   int n_errors = 0;
   int n_tests = 0;
   logic [31:0] rd;
   // Command words and the bank idle pattern that each should leave.
   localparam int NROW = 20;
   logic [31:0] row_cmd [NROW] = '{32'h00200005, 32'h00000001, 32'h00000011, 32'h00000021, 32'h00000014,
      32'h00000064, 32'h00000031, 32'h00000032, 32'h00000072, 32'h00000001, 32'h00000043, 32'h00270005,
      32'h00000021, 32'h00000062, 32'h00000024, 32'h02270005, 32'h00000011, 32'h00000053, 32'h00000044,
      32'h00000000};
   logic [3:0] row_idle [NROW] = '{4'hf, 4'he, 4'hc, 4'h8, 4'ha, 4'hf, 4'h7, 4'h7, 4'hf, 4'he, 4'hf, 4'hf,
      4'hb, 4'hb, 4'hf, 4'hf, 4'hd, 4'hd, 4'hf, 4'hf};
   sbp_link_if lk();
   sbp_ctl sbp_ctl_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hrdata(hrdata), .o_hresp(hresp), .link(lk));
   sbp_device sbp_device_i (.i_clk(i_clk), .i_resetn(i_resetn), .link(lk), .o_bank_idle(bank_idle));
   sbp_checker sbp_checker_i (.i_clk(i_clk), .i_resetn(i_resetn), .cmd(lk.cmd), .ba(lk.ba), .a10(lk.a10),
      .addr(lk.addr), .dqm(lk.dqm), .dq_ctl_oe(lk.dq_ctl_oe), .dq_dev_oe(lk.dq_dev_oe),
      .o_bank_idle(bank_idle));
   always #20 i_clk = ~i_clk;
   // ======================================================================
   // Tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge i_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // The settle wait covers the longest burst plus row active and precharge times.
   task automatic order(input logic [31:0] w);
      logic [31:0] s;
      ahb(1'b1, 8'h00, w, s);
      do ahb(1'b0, 8'h08, 32'h0, s); while (s[0] !== 1'b0);
      repeat (16) @(posedge i_clk);
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ======================================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      chk("idle in reset", 32'hf, {28'h0, bank_idle});
      @(posedge i_clk);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("status after reset", 32'h0, rd);
      chk("response", 32'h0, {31'h0, hresp});
      $display("Test reset done");
      for (int i = 0; i < NROW; i++) begin
         order(row_cmd[i]);
         chk("bank idle", {28'h0, row_idle[i]}, {28'h0, bank_idle});
      end
      $display("Test command table done");
      order(32'h00220005);
      ahb(1'b1, 8'h04, 32'h0000aaaa, rd);
      order(32'h00000001);
      order(32'h00000003);
      order(32'h00000044);
      order(32'h02220005);
      order(32'h00000001);
      ahb(1'b1, 8'h04, 32'h00005555, rd);
      order(32'h00000003);
      order(32'h00000002);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("word captured", 32'h2, rd & 32'h2);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk("last burst word", 32'h0000aaaa, rd);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("word flag cleared", 32'h0, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      $display("Test single write mode done");
      order(32'h00000044);
      order(32'h00230005);
      order(32'h00000001);
      order(32'h00000011);
      // The read is ordered at once, so the write lands while the read burst still runs.
      ahb(1'b1, 8'h00, 32'h00000042, rd);
      order(32'h00000013);
      chk("interrupted read", 32'hd, {28'h0, bank_idle});
      $display("Test interrupted read done");
      // Each pair below lands the second access inside the first auto precharge burst.
      order(32'h00000001);
      ahb(1'b1, 8'h00, 32'h00000053, rd);
      order(32'h00000003);
      chk("write interrupts write", 32'he, {28'h0, bank_idle});
      order(32'h00000011);
      ahb(1'b1, 8'h00, 32'h00000043, rd);
      order(32'h00000012);
      chk("read interrupts write", 32'hd, {28'h0, bank_idle});
      order(32'h00000001);
      ahb(1'b1, 8'h00, 32'h00000042, rd);
      order(32'h00000012);
      chk("read interrupts read", 32'hd, {28'h0, bank_idle});
      $display("Test concurrent auto precharge done");
      i_resetn <= 1'b0;
      @(posedge i_clk);
      chk("idle in mid-run reset", 32'hf, {28'h0, bank_idle});
      i_resetn <= 1'b1;
      @(posedge i_clk);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("status after mid-run reset", 32'h0, rd);
      $display("Test mid-run reset done");
      end_of_test();
   end
   // Watchdog: the run needs under a thousand cycles, this allows twenty thousand.
   initial begin
      #800000;
      n_errors++;
      $display("BAD watchdog expected done seen hang");
      end_of_test();
   end
endmodule // tb_sdram_bank_precharge_control
`default_nettype wire
